/* File: core/dioc_in_cond.sv */
/*
 * dioc_in_cond: one input channel, three-flop synchroniser, debounce
 * filter and pulse extension.
 * assumes filt_sel and ext_sel come from logic on the same clock.
 */
`timescale 1ns/10ps
module dioc_in_cond import dioc_pkg::*; #(
	parameter int unsigned F0 = FILT0_CYC,
	parameter int unsigned F1 = FILT1_CYC,
	parameter int unsigned F2 = FILT2_CYC,
	parameter int unsigned F3 = FILT3_CYC,
	parameter int unsigned E0 = EXT0_CYC,
	parameter int unsigned E1 = EXT1_CYC,
	parameter int unsigned E2 = EXT2_CYC,
	parameter int unsigned E3 = EXT3_CYC
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic pin_i,
	input wire logic [1:0] filt_sel_i,
	input wire logic [1:0] ext_sel_i,
	output logic din_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic stable;
		logic out;
		logic [TMR_W-1:0] ftmr;
		logic [TMR_W-1:0] etmr;
	} st_t;
	st_t q, d;
	logic [TMR_W-1:0] flim, elim;

	// selected filter and extension limits
	always_comb begin
		case (filt_sel_i)
			2'h0: flim = TMR_W'(F0);
			2'h1: flim = TMR_W'(F1);
			2'h2: flim = TMR_W'(F2);
			default: flim = TMR_W'(F3);
		endcase
		case (ext_sel_i)
			2'h0: elim = TMR_W'(E0);
			2'h1: elim = TMR_W'(E1);
			2'h2: elim = TMR_W'(E2);
			default: elim = TMR_W'(E3);
		endcase
	end

	// debounce then stretch
	always_comb begin
		d = q;
		d.s1 = pin_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3 && q.s2 != q.stable) begin
			// a change must persist for the whole filter time
			if (q.ftmr >= flim - TMR_W'(1)) begin
				d.stable = q.s2;
				d.ftmr = '0;
			end else begin
				d.ftmr = q.ftmr + TMR_W'(1);
			end
		end else begin
			d.ftmr = '0; // short glitch discarded
		end
		if (q.stable) begin
			d.out = 1'b1;
			d.etmr = '0;
		end else if (q.out) begin
			if (q.etmr >= elim - TMR_W'(1)) begin
				d.out = 1'b0;
				d.etmr = '0;
			end else begin
				d.etmr = q.etmr + TMR_W'(1);
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign din_o = q.out;
endmodule

/* File: core/dioc_top.sv */
/*
 * dioc_top: digital io channel conditioning with register port,
 * diagnostics, output fault and idle handling and operation counters.
 * assumes pins are asynchronous, comm_fault_i/comm_idle_i and the register
 * port are on ref_clk_i, and a persistent store keeps nv_cnt_o between
 * power cycles and returns it on nv_cnt_i after reset.
 */
// The address map and strobed register access were decided locally.
// Summary of operation
// - supply short raises an error only while its detection is enabled
// - inrush filter blanks overcurrent detection for 100 ms after power-up
// - input changes shorter than the unit filter time 0.1/1/10/20 ms ignored
// - detected input held for extension time 1/15/100/200 ms, default 15
// - load short raises an error only while load short detection is enabled
// - auto restart clears short error when gone; manual holds until reset
// - per-channel open circuit detection raises an error, off by default
// - on communication fault each output goes clear, hold or forced on
// - on communication idle each output goes to its own clear/hold/on choice
// - per-channel fault and idle choices act only under software priority
// - counters are saved hourly and resume from saved value after reset
// - counter threshold is the set value times one thousand
// - with check enabled, count above threshold raises a channel error
// - counter clear command zeroes the selected channel counters
`timescale 1ns/10ps
module dioc_top import dioc_pkg::*; #(
	parameter int N = 8,
	parameter int unsigned F0 = FILT0_CYC,
	parameter int unsigned F1 = FILT1_CYC,
	parameter int unsigned F2 = FILT2_CYC,
	parameter int unsigned F3 = FILT3_CYC,
	parameter int unsigned E0 = EXT0_CYC,
	parameter int unsigned E1 = EXT1_CYC,
	parameter int unsigned E2 = EXT2_CYC,
	parameter int unsigned E3 = EXT3_CYC,
	parameter logic [BLANK_W-1:0] BLANK_CYC = BLANK_W'(INRUSH_CYC),
	parameter logic [HOUR_W-1:0] HOUR_CYC = SAVE_CYC
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [N-1:0] din_pin_i,
	input wire logic supply_short_pin_i,
	input wire logic [N-1:0] load_short_pin_i,
	input wire logic [N-1:0] open_load_pin_i,
	input wire logic comm_fault_i,
	input wire logic comm_idle_i,
	output logic [N-1:0] dout_o,
	output logic irq_o,
	input wire logic [N-1:0][CNT_W-1:0] nv_cnt_i,
	output logic nv_save_o,
	output logic [N-1:0][CNT_W-1:0] nv_cnt_o
);
	localparam int PW = 2 * N + 1; // supply, load short and open pins

	typedef struct packed {
		dioc_ctrl_t ctrl;
		logic [N-1:0] open_en;
		logic [2*N-1:0] fault_mode;
		logic [2*N-1:0] idle_mode;
		logic [N-1:0] out_data;
		logic [N-1:0] dout;
		logic [N-1:0] err_short;
		logic [N-1:0] err_open;
		logic [N-1:0] err_cnt;
		logic sup_err;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mk;
		logic [15:0] thr;
		logic [3:0] cnt_sel;
		logic [N-1:0][CNT_W-1:0] cnt;
		logic [N-1:0][CNT_W-1:0] nv_cnt;
		logic nv_save;
		logic restored;
		logic [HOUR_W-1:0] hour;
		logic [BLANK_W-1:0] blank;
		logic [31:0] rdata;
		logic [PW-1:0] s1;
		logic [PW-1:0] s2;
		logic [PW-1:0] s3;
		logic [PW-1:0] pin_f;
		logic [N-1:0] in_prev;
	} st_t;

	st_t q, d;
	dioc_bus_t bus;
	logic [N-1:0] din_c;
	logic [PW-1:0] pins;
	logic sup_det;
	logic [N-1:0] short_det, open_det;
	logic blanking;
	logic [31:0] thr_cnt;
	logic [IRQ_W-1:0] ev;
	logic [31:0] rd_val;

	// bundle the register port and the diagnostic pins
	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	assign pins = {open_load_pin_i, load_short_pin_i, supply_short_pin_i};

	// per-channel input conditioning
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_in
			dioc_in_cond #(
				.F0(F0), .F1(F1), .F2(F2), .F3(F3),
				.E0(E0), .E1(E1), .E2(E2), .E3(E3)
			) u_in (
				.ref_clk_i(ref_clk_i),
				.reset_i(reset_i),
				.ce_i(ce_i),
				.pin_i(din_pin_i[gi]),
				.filt_sel_i(q.ctrl.filt_sel),
				.ext_sel_i(q.ctrl.ext_sel),
				.din_o(din_c[gi])
			);
		end
	endgenerate

	// detector levels, supply and load short after blanking, open circuit unblanked
	assign blanking = q.ctrl.inrush_en && (q.blank < BLANK_CYC);
	assign sup_det = q.pin_f[0] && !blanking;
	assign short_det = q.pin_f[N:1] & {N{!blanking}};
	assign open_det = q.pin_f[2*N:N+1];
	assign thr_cnt = 32'(q.thr) * CNT_SCALE;

	// register read mux
	always_comb begin
		rd_val = '0;
		case (bus.addr)
			REG_CTRL: rd_val = 32'(q.ctrl);
			REG_OPEN_EN: rd_val = 32'(q.open_en);
			REG_FAULT_MODE: rd_val = 32'(q.fault_mode);
			REG_IDLE_MODE: rd_val = 32'(q.idle_mode);
			REG_OUT_DATA: rd_val = 32'(q.out_data);
			REG_IN_STATE: rd_val = 32'(din_c);
			REG_IRQ_STAT: rd_val = 32'(q.irq_st);
			REG_IRQ_MASK: rd_val = 32'(q.irq_mk);
			REG_ERR_SHORT: rd_val = 32'(q.err_short);
			REG_ERR_OPEN: rd_val = 32'(q.err_open);
			REG_ERR_CNT: rd_val = 32'(q.err_cnt);
			REG_THRESH: rd_val = 32'(q.thr);
			REG_CNT_SEL: rd_val = 32'(q.cnt_sel);
			REG_CNT_VAL: begin
				if (int'(q.cnt_sel) < N) begin
					rd_val = q.cnt[q.cnt_sel];
				end
			end
			REG_UNIT_DIAG: rd_val = 32'(q.sup_err);
			default: rd_val = '0;
		endcase
	end

	// next state of the whole block
	always_comb begin
		d = q;
		// three-flop synchroniser, change taken when stages two and three agree
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.pin_f = (q.s2 & q.s3) | (q.pin_f & (q.s2 | q.s3));
		d.in_prev = din_c;
		d.nv_save = 1'b0;
		// read data stands in the cycle after the strobe only
		d.rdata = bus.rd ? rd_val : '0;

		// register writes
		if (bus.wr) begin
			case (bus.addr)
				REG_CTRL: d.ctrl = dioc_ctrl_t'(bus.wdata[CTRL_W-1:0]);
				REG_OPEN_EN: d.open_en = bus.wdata[N-1:0];
				REG_FAULT_MODE: d.fault_mode = bus.wdata[2*N-1:0];
				REG_IDLE_MODE: d.idle_mode = bus.wdata[2*N-1:0];
				REG_OUT_DATA: d.out_data = bus.wdata[N-1:0];
				REG_IRQ_MASK: d.irq_mk = bus.wdata[IRQ_W-1:0];
				REG_THRESH: d.thr = bus.wdata[15:0];
				REG_CNT_SEL: d.cnt_sel = bus.wdata[3:0];
				default: d.thr = d.thr;
			endcase
		end

		// inrush window timer runs from reset release and then stops
		if (q.blank < BLANK_CYC) begin
			d.blank = q.blank + BLANK_W'(1);
		end

		// supply short diagnostic follows the detector while enabled
		d.sup_err = q.ctrl.supply_short_en && sup_det;

		// load short diagnostic, auto restart or latched until reset
		if (q.ctrl.restart_manual) begin
			d.err_short = q.err_short | (short_det & {N{q.ctrl.load_short_en}});
		end else begin
			d.err_short = short_det & {N{q.ctrl.load_short_en}};
		end

		// open circuit diagnostic per channel
		d.err_open = open_det & q.open_en;

		// output choice per channel
		for (int i = 0; i < N; i++) begin
			dioc_omode_t m;
			m = om_clear;
			if (comm_fault_i) begin
				m = dioc_omode_t'(q.fault_mode[2*i+:2]);
			end else if (comm_idle_i) begin
				m = dioc_omode_t'(q.idle_mode[2*i+:2]);
			end
			if (!q.ctrl.sw_priority) begin
				m = om_clear;
			end
			if (!comm_fault_i && !comm_idle_i) begin
				d.dout[i] = q.out_data[i];
			end else begin
				case (m)
					om_clear: d.dout[i] = 1'b0;
					om_hold: d.dout[i] = q.dout[i];
					drive_output_high_forcibly: d.dout[i] = 1'b1;
					default: d.dout[i] = 1'b0;
				endcase
			end
		end

		// operation counters count output switch-on events
		for (int i = 0; i < N; i++) begin
			if (!q.restored) begin
				d.cnt[i] = nv_cnt_i[i];
			end else if (bus.wr && bus.addr == REG_CNT_CLR && bus.wdata[i]) begin
				d.cnt[i] = '0;
			end else if (d.dout[i] && !q.dout[i]) begin
				d.cnt[i] = q.cnt[i] + CNT_W'(1);
			end
			d.err_cnt[i] = q.ctrl.cnt_chk_en && (q.cnt[i] > thr_cnt);
		end
		d.restored = 1'b1;

		// hourly snapshot for the persistent store
		if (q.hour >= HOUR_CYC - HOUR_W'(1)) begin
			d.hour = '0;
			d.nv_cnt = q.cnt;
			d.nv_save = 1'b1;
		end else begin
			d.hour = q.hour + HOUR_W'(1);
		end

		// sticky event bits, a new event beats a same-cycle clear
		ev = '0;
		ev[IRQ_SUPPLY] = d.sup_err && !q.sup_err;
		ev[IRQ_SHORT] = |(d.err_short & ~q.err_short);
		ev[IRQ_OPEN] = |(d.err_open & ~q.err_open);
		ev[IRQ_CNT] = |(d.err_cnt & ~q.err_cnt);
		ev[IRQ_INPUT] = |(din_c ^ q.in_prev);
		if (bus.wr && bus.addr == REG_IRQ_STAT) begin
			d.irq_st = q.irq_st & ~bus.wdata[IRQ_W-1:0];
		end
		d.irq_st = d.irq_st | ev;
	end

	// state register
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			q <= '0;
			q.ctrl <= dioc_ctrl_t'(CTRL_RST);
			q.thr <= THRESH_RST;
		end else if (ce_i) begin
			q <= d;
		end
	end

	// outputs straight from state
	assign rdata_o = q.rdata;
	assign dout_o = q.dout;
	assign irq_o = |(q.irq_st & q.irq_mk);
	assign nv_save_o = q.nv_save;
	assign nv_cnt_o = q.nv_cnt;
endmodule

/* File: inc/dioc_pkg.sv */
/*
 * dioc_pkg: constants, register map and carrier types of the digital io
 * channel conditioning block.
 * assumes a 10 MHz module clock and a word-aligned 8-bit register address.
 */
package dioc_pkg;
	// clock rate
	localparam longint unsigned CLK_HZ = 64'd10_000_000;
	localparam longint unsigned US_DIV = 64'd1_000_000;
	// input filter times in microseconds, selected by ctrl.filt_sel
	localparam longint unsigned FILT0_US = 64'd100;
	localparam longint unsigned FILT1_US = 64'd1000;
	localparam longint unsigned FILT2_US = 64'd10000;
	localparam longint unsigned FILT3_US = 64'd20000;
	// input extension times in microseconds, selected by ctrl.ext_sel
	localparam longint unsigned EXT0_US = 64'd1000;
	localparam longint unsigned EXT1_US = 64'd15000;
	localparam longint unsigned EXT2_US = 64'd100000;
	localparam longint unsigned EXT3_US = 64'd200000;
	// inrush blanking window and counter save interval
	localparam longint unsigned INRUSH_US = 64'd100000;
	localparam longint unsigned SAVE_S = 64'd3600;
	// least times round up to whole cycles
	localparam int unsigned FILT0_CYC = 32'((FILT0_US * CLK_HZ + US_DIV - 1) / US_DIV);
	localparam int unsigned FILT1_CYC = 32'((FILT1_US * CLK_HZ + US_DIV - 1) / US_DIV);
	localparam int unsigned FILT2_CYC = 32'((FILT2_US * CLK_HZ + US_DIV - 1) / US_DIV);
	localparam int unsigned FILT3_CYC = 32'((FILT3_US * CLK_HZ + US_DIV - 1) / US_DIV);
	localparam int unsigned EXT0_CYC = 32'((EXT0_US * CLK_HZ + US_DIV - 1) / US_DIV);
	localparam int unsigned EXT1_CYC = 32'((EXT1_US * CLK_HZ + US_DIV - 1) / US_DIV);
	localparam int unsigned EXT2_CYC = 32'((EXT2_US * CLK_HZ + US_DIV - 1) / US_DIV);
	localparam int unsigned EXT3_CYC = 32'((EXT3_US * CLK_HZ + US_DIV - 1) / US_DIV);
	localparam int unsigned INRUSH_CYC = 32'((INRUSH_US * CLK_HZ + US_DIV - 1) / US_DIV);
	localparam logic [35:0] SAVE_CYC = 36'(SAVE_S * CLK_HZ);
	// timer widths
	localparam int TMR_W = 22;
	localparam int BLANK_W = 21;
	localparam int HOUR_W = 36;
	localparam int CNT_W = 32;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OPEN_EN = 8'h04;
	localparam logic [7:0] REG_FAULT_MODE = 8'h08;
	localparam logic [7:0] REG_IDLE_MODE = 8'h0c;
	localparam logic [7:0] REG_OUT_DATA = 8'h10;
	localparam logic [7:0] REG_IN_STATE = 8'h14;
	localparam logic [7:0] REG_IRQ_STAT = 8'h18;
	localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
	localparam logic [7:0] REG_ERR_SHORT = 8'h20;
	localparam logic [7:0] REG_ERR_OPEN = 8'h24;
	localparam logic [7:0] REG_ERR_CNT = 8'h28;
	localparam logic [7:0] REG_THRESH = 8'h2c;
	localparam logic [7:0] REG_CNT_CLR = 8'h30;
	localparam logic [7:0] REG_CNT_SEL = 8'h34;
	localparam logic [7:0] REG_CNT_VAL = 8'h38;
	localparam logic [7:0] REG_UNIT_DIAG = 8'h3c;

	// unit control register, bit 0 first from the right
	typedef struct packed {
		logic cnt_chk_en;
		logic sw_priority;
		logic restart_manual;
		logic load_short_en;
		logic [1:0] ext_sel;
		logic [1:0] filt_sel;
		logic inrush_en;
		logic supply_short_en;
	} dioc_ctrl_t;
	localparam int CTRL_W = 10;
	localparam logic [9:0] CTRL_RST = 10'h014;

	// interrupt status and mask bit positions
	localparam int IRQ_SUPPLY = 0;
	localparam int IRQ_SHORT = 1;
	localparam int IRQ_OPEN = 2;
	localparam int IRQ_CNT = 3;
	localparam int IRQ_INPUT = 4;
	localparam int IRQ_W = 5;

	// counter threshold
	localparam logic [15:0] THRESH_RST = 16'h0001;
	localparam logic [31:0] CNT_SCALE = 32'd1000;

	// per-channel output choice on fault or idle
	typedef enum logic [1:0] {
		om_clear,
		om_hold,
		drive_output_high_forcibly
	} dioc_omode_t;

	// register bus request carried inside the block
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dioc_bus_t;
endpackage

/* File: testbench/dioc_field_model.sv */
/*
 * dioc_field_model: field loads beside the outputs and the persistent counter store.
 * assumes dout_i and nv_save_i come from the block on ref_clk_i.
 */
`timescale 1ns/10ps
module dioc_field_model import dioc_pkg::*; #(
	parameter int N = 8,
	parameter logic [CNT_W-1:0] INIT0 = 32'd1000
) (
	input wire logic ref_clk_i,
	input wire logic [N-1:0] dout_i,
	input wire logic [N-1:0] short_cmd_i,
	input wire logic [N-1:0] open_cmd_i,
	input wire logic nv_save_i,
	input wire logic [N-1:0][CNT_W-1:0] snap_i,
	output logic [N-1:0] load_short_pin_o,
	output logic [N-1:0] open_load_pin_o,
	output logic [N-1:0][CNT_W-1:0] store_o
);
	// a shorted load only shows while its channel drives it; a broken wire always shows
	assign load_short_pin_o = short_cmd_i & dout_i;
	assign open_load_pin_o = open_cmd_i;
	// store starts with channel 0 preloaded and keeps the last snapshot across resets
	initial begin
		store_o = '0;
		store_o[0] = INIT0;
	end
	always @(posedge ref_clk_i) begin
		if (nv_save_i) begin
			store_o <= snap_i;
		end
	end
endmodule

/* File: testbench/dioc_top_sva.sv */
/*
 * dioc_top_sva: port-level checks of dioc_top, bound into every instance.
 * assumes resets last at least two cycles; the save gap only counts enabled cycles.
 */
`timescale 1ns/10ps
module dioc_top_sva import dioc_pkg::*; #(
	parameter int N = 8,
	parameter logic [HOUR_W-1:0] HOUR_CYC = SAVE_CYC
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic supply_short_pin_i,
	input wire logic comm_fault_i,
	input wire logic comm_idle_i,
	input wire logic [N-1:0] dout_o,
	input wire logic irq_o,
	input wire logic nv_save_o,
	input wire logic [N-1:0][CNT_W-1:0] nv_cnt_o
);
	logic [3:0] quiet_ff;
	logic [HOUR_W-1:0] gap_ff;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// cycles the supply pin stayed low, and cycles since the last save
	always_ff @(posedge ref_clk_i) begin
		quiet_ff <= (reset_i || supply_short_pin_i) ? 4'h0 : quiet_ff + 4'(quiet_ff != 4'hf);
		gap_ff <= (reset_i || nv_save_o) ? '0 : gap_ff + HOUR_W'(ce_i);
	end
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (rd_i && addr_i > REG_UNIT_DIAG |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_upper: assert property (rd_i && addr_i == REG_CTRL |=> rdata_o[31:CTRL_W] == '0)
		else $error("control upper bits not zero");
	a_diag_quiet: assert property (rd_i && addr_i == REG_UNIT_DIAG && quiet_ff > 4'hb |=> !rdata_o[0])
		else $error("supply error without a short");
	a_irq_masked: assert property (wr_i && addr_i == REG_IRQ_MASK && wdata_i[IRQ_W-1:0] == '0 |=> !irq_o)
		else $error("interrupt high with all masked");
	a_dout_follow: assert property ((wr_i && addr_i == REG_OUT_DATA && !comm_fault_i && !comm_idle_i) ##1
		(!wr_i && !comm_fault_i && !comm_idle_i) |=> dout_o == $past(wdata_i[N-1:0], 2))
		else $error("output does not follow output data");
	a_save_pulse: assert property (nv_save_o |=> !nv_save_o)
		else $error("save pulse longer than one cycle");
	a_save_hold: assert property (!nv_save_o && !$past(reset_i) |-> $stable(nv_cnt_o))
		else $error("snapshot changed without a save");
	a_save_period: assert property (nv_save_o |-> gap_ff >= HOUR_CYC - 2 && gap_ff <= HOUR_CYC + 1)
		else $error("save interval wrong");
	c_save: cover property (nv_save_o);
	c_irq: cover property (irq_o);
	c_fault_out: cover property (comm_fault_i && dout_o != '0);
endmodule
bind dioc_top dioc_top_sva #(.N(N), .HOUR_CYC(HOUR_CYC)) i_sva (.ref_clk_i(ref_clk_i),
	.reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .supply_short_pin_i(supply_short_pin_i), .comm_fault_i(comm_fault_i),
	.comm_idle_i(comm_idle_i), .dout_o(dout_o), .irq_o(irq_o), .nv_save_o(nv_save_o),
	.nv_cnt_o(nv_cnt_o));

/* File: testbench/tb.sv */
/*
 * tb: self-checking bench of dioc_top with the field and store model.
 * assumes the shortened filter, stretch, blanking and save counts set at i_dut.
 */
`timescale 1ns/10ps
module tb import dioc_pkg::*;;
	logic ref_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, supply_pin = 1'b0;
	logic comm_fault = 1'b0, comm_idle = 1'b0, irq_o, nv_save_o;
	logic [7:0] addr_i = 8'h00, din_pin = 8'h00, short_cmd = 8'h00, open_cmd = 8'h00;
	logic [7:0] dout_o, load_pin, open_pin;
	logic [31:0] wdata_i = 32'h0, rdata_o;
	logic [7:0][CNT_W-1:0] nv_store, nv_snap;
	logic ce = 1'b1;
	int n_mismatch = 0, cmp_count = 0;
	// shortened timings so every window fits the run
	localparam int NCH = 8;
	localparam int unsigned TF0 = 4, TF1 = 6, TF2 = 8, TF3 = 10;
	localparam int unsigned TE0 = 5, TE1 = 7, TE2 = 9, TE3 = 11;
	localparam logic [BLANK_W-1:0] TBLANK = 21'd40;
	localparam logic [HOUR_W-1:0] THOUR = 36'd200;
	always #50 ref_clk_i = ~ref_clk_i;
	dioc_top #(.N(NCH), .F0(TF0), .F1(TF1), .F2(TF2), .F3(TF3), .E0(TE0), .E1(TE1), .E2(TE2),
		.E3(TE3), .BLANK_CYC(TBLANK), .HOUR_CYC(THOUR)) i_dut (.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .din_pin_i(din_pin), .supply_short_pin_i(supply_pin),
		.load_short_pin_i(load_pin), .open_load_pin_i(open_pin), .comm_fault_i(comm_fault),
		.comm_idle_i(comm_idle), .dout_o(dout_o), .irq_o(irq_o), .nv_cnt_i(nv_store),
		.nv_save_o(nv_save_o), .nv_cnt_o(nv_snap));
	dioc_field_model #(.N(NCH)) i_field (.ref_clk_i(ref_clk_i), .dout_i(dout_o),
		.short_cmd_i(short_cmd), .open_cmd_i(open_cmd), .nv_save_i(nv_save_o),
		.snap_i(nv_snap), .load_short_pin_o(load_pin), .open_load_pin_o(open_pin),
		.store_o(nv_store));
	// compare, count and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic rst();
		reset_i <= 1'b1;
		cyc(12);
		reset_i <= 1'b0;
	endtask
	// register bus: one-cycle strobes, read data taken in the cycle after the strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask
	task automatic ic(input logic exp);
		@(posedge ref_clk_i);
		#1;
		chk(32'(irq_o), 32'(exp));
	endtask
	// blanking just after reset, then detection once the window has passed
	task automatic t_inrush();
		rc(REG_CTRL, 32'(CTRL_RST));
		wr(REG_CTRL, 32'h017);
		supply_pin <= 1'b1;
		cyc(8);
		rc(REG_UNIT_DIAG, 32'h0);
		cyc(30);
		rc(REG_UNIT_DIAG, 32'h1);
		supply_pin <= 1'b0;
		cyc(12);
		rc(REG_UNIT_DIAG, 32'h0);
		$display("t_inrush done");
	endtask
	task automatic t_defaults();
		rc(REG_THRESH, 32'(THRESH_RST));
		rc(REG_OPEN_EN, 32'h0);
		rc(REG_FAULT_MODE, 32'h0);
		rc(REG_IDLE_MODE, 32'h0);
		rc(8'h40, 32'h0);
		// a write while the clock enable is low must leave the threshold alone
		@(posedge ref_clk_i);
		ce <= 1'b0;
		wr(REG_THRESH, 32'h5);
		ce <= 1'b1;
		rc(REG_THRESH, 32'(THRESH_RST));
		$display("t_defaults done");
	endtask
	// channel 0 resumes at 1000, the threshold boundary, then one more switch-on
	task automatic t_counter();
		wr(REG_CTRL, 32'h214);
		rc(REG_CNT_VAL, 32'd1000);
		rc(REG_ERR_CNT, 32'h0);
		wr(REG_OUT_DATA, 32'h1);
		cyc(3);
		rc(REG_ERR_CNT, 32'h1);
		rc(REG_CNT_VAL, 32'd1001);
		wr(REG_THRESH, 32'h2);
		rc(REG_ERR_CNT, 32'h0);
		wr(REG_CNT_CLR, 32'h1);
		rc(REG_CNT_VAL, 32'h0);
		$display("t_counter done");
	endtask
	task automatic t_save();
		int n;
		wr(REG_OUT_DATA, 32'h0);
		wr(REG_OUT_DATA, 32'h1);
		wr(REG_OUT_DATA, 32'h0);
		wr(REG_OUT_DATA, 32'h1);
		cyc(4);
		n = 0;
		while (nv_save_o !== 1'b1 && n < 400) begin
			@(posedge ref_clk_i);
			n++;
		end
		chk(nv_snap[0], 32'd2);
		rst();
		rc(REG_CNT_VAL, 32'd2);
		$display("t_save done");
	endtask
	// glitches shorter than the filter vanish; the stretch length follows its choice
	task automatic t_filter();
		wr(REG_CTRL, 32'h000);
		din_pin <= 8'h01;
		cyc(2);
		din_pin <= 8'h00;
		cyc(12);
		rc(REG_IN_STATE, 32'h0);
		din_pin <= 8'h01;
		cyc(20);
		rc(REG_IN_STATE, 32'h1);
		din_pin <= 8'h00;
		cyc(13);
		rc(REG_IN_STATE, 32'h0);
		wr(REG_CTRL, 32'h03c);
		din_pin <= 8'h01;
		cyc(7);
		din_pin <= 8'h00;
		cyc(20);
		rc(REG_IN_STATE, 32'h0);
		din_pin <= 8'h01;
		cyc(30);
		din_pin <= 8'h00;
		cyc(13);
		rc(REG_IN_STATE, 32'h1);
		cyc(20);
		rc(REG_IN_STATE, 32'h0);
		$display("t_filter done");
	endtask
	task automatic t_supply();
		wr(REG_IRQ_STAT, 32'h1f);
		wr(REG_IRQ_MASK, 32'h1);
		ic(1'b0);
		supply_pin <= 1'b1;
		cyc(12);
		rc(REG_UNIT_DIAG, 32'h0);
		wr(REG_CTRL, 32'h015);
		cyc(12);
		rc(REG_UNIT_DIAG, 32'h1);
		ic(1'b1);
		wr(REG_IRQ_MASK, 32'h0);
		ic(1'b0);
		wr(REG_IRQ_MASK, 32'h1);
		supply_pin <= 1'b0;
		cyc(12);
		rc(REG_UNIT_DIAG, 32'h0);
		ic(1'b1);
		wr(REG_IRQ_STAT, 32'h1);
		ic(1'b0);
		$display("t_supply done");
	endtask
	// load short off, automatic restart, then manual restart on channel 1
	task automatic t_short();
		wr(REG_OUT_DATA, 32'h2);
		wr(REG_CTRL, 32'h014);
		short_cmd <= 8'h02;
		cyc(12);
		rc(REG_ERR_SHORT, 32'h0);
		wr(REG_CTRL, 32'h054);
		cyc(12);
		rc(REG_ERR_SHORT, 32'h2);
		short_cmd <= 8'h00;
		cyc(12);
		rc(REG_ERR_SHORT, 32'h0);
		wr(REG_CTRL, 32'h0d4);
		short_cmd <= 8'h02;
		cyc(12);
		short_cmd <= 8'h00;
		cyc(12);
		rc(REG_ERR_SHORT, 32'h2);
		$display("t_short done");
	endtask
	task automatic t_open();
		open_cmd <= 8'h04;
		cyc(12);
		rc(REG_ERR_OPEN, 32'h0);
		wr(REG_OPEN_EN, 32'h4);
		cyc(4);
		rc(REG_ERR_OPEN, 32'h4);
		open_cmd <= 8'h00;
		$display("t_open done");
	endtask
	// channel modes: fault 0 clear 1 hold 2 on 3 clear, idle 0 hold 3 on
	task automatic t_outputs();
		wr(REG_OUT_DATA, 32'h0b);
		wr(REG_FAULT_MODE, 32'he4);
		wr(REG_IDLE_MODE, 32'h81);
		wr(REG_CTRL, 32'h114);
		comm_idle <= 1'b1;
		cyc(4);
		chk(32'(dout_o), 32'h09);
		comm_idle <= 1'b0;
		cyc(4);
		comm_fault <= 1'b1;
		cyc(4);
		chk(32'(dout_o), 32'h06);
		comm_idle <= 1'b1;
		cyc(4);
		chk(32'(dout_o), 32'h06);
		wr(REG_CTRL, 32'h014);
		cyc(4);
		chk(32'(dout_o), 32'h00);
		comm_fault <= 1'b0;
		comm_idle <= 1'b0;
		$display("t_outputs done");
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		rst();
		t_inrush();
		t_defaults();
		t_counter();
		t_save();
		t_filter();
		t_supply();
		t_short();
		t_open();
		t_outputs();
		conclude();
	end
	// cut a hang short
	initial begin
		cyc(5000);
		n_mismatch++;
		conclude();
	end
endmodule
